// File: verilog/irq_entry_pkg.sv
// constants, states and register map of the interrupt entry logic
// assumes one 10 MHz clock; four clocks form one instruction cycle
// Overview of operation
// R1: synchronous event reaches vector in 3-4 cycles
// R2: asynchronous event reaches vector in 3-5 cycles
// R3: latency same for one- or two-cycle instructions
// R4: latency counted from event to vector execution
// R5: pin flag may set over Q4 to Q1
// R6: only clockless-capable sources wake from sleep
// R7: software enables wake sources before sleeping
// R8: wake with global enable set takes vector
// R9: wake with global enable clear just resumes
// R10: instruction after sleep always runs first
// R11: pin interrupt is async edge, needs enable
// R12: edge select set rising, clear falling
// R13: valid selected edge sets pin flag
// R14: flag plus both enables redirects to vector
// R15: return address pushed on entry
// R16: context copied to shadows on entry
// R17: return restores every shadowed register
// R18: shadow writes become restored live values
// R19: shadows in bank 31, read and write
// R20: entry flushes fetch, clears enable, loads vector
// R21: return pops, restores, sets global enable
// R22: flags set whatever the enables say
// R23: entry inserts no-ops until vector fetched
`default_nettype none

package irq_entry_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TCY_NS = 400;
  localparam int TCY_CLKS = TCY_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] WAKE_HOLD_TCY = 2'h1;
  // ----------------------------------------
  // program counter
  // ----------------------------------------
  localparam int PC_W = 15;
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] EDGE_OFF = 12'h004;
  localparam logic [11:0] STATE_OFF = 12'h008;
  localparam logic [4:0] SHADOW_BANK = 5'h1f;
  localparam logic [11:0] SHADOW_BASE = {SHADOW_BANK, 7'h00};
  localparam int CTRL_GIE_BIT = 7;
  localparam int CTRL_INTE_BIT = 4;
  localparam int CTRL_FLAG_BIT = 1;
  localparam int EDGE_SEL_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic EDGE_RESET = 1'b0;
  // ----------------------------------------
  // shadow layout, one byte each
  // ----------------------------------------
  localparam int SHADOW_COUNT = 8;
  localparam logic [2:0] SH_W = 3'h0;
  localparam logic [2:0] SH_STATUS = 3'h1;
  localparam logic [2:0] SH_BSR = 3'h2;
  localparam logic [2:0] SH_PC_HIGH_LATCH = 3'h3;
  localparam logic [2:0] SH_FSR0L = 3'h4;
  localparam logic [2:0] SH_FSR0H = 3'h5;
  localparam logic [2:0] SH_FSR1L = 3'h6;
  localparam logic [2:0] SH_FSR1H = 3'h7;
  localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  // ----------------------------------------
  // entry sequence
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SAMPLED = 5'b00010,
    ST_NOP1 = 5'b00100,
    ST_NOP2 = 5'b01000,
    ST_VECTOR = 5'b10000
  } entry_state_type;
endpackage : irq_entry_pkg

`default_nettype wire

// File: verilog/ext_edge_detect.sv
// synchroniser and edge detector for the external interrupt pin
// assumes the pin is asynchronous to mclk
`default_nettype none

module ext_edge_detect
  import irq_entry_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // pin and selection
  input wire logic extPin,
  input wire logic risingSel,
  // detected edge, one clock
  output logic edgeSeen
);
  logic syncA_reg;
  logic syncB_reg;
  logic last_reg;

  // ----------------------------------------
  // two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      syncA_reg <= extPin;
      syncB_reg <= syncA_reg;
      last_reg <= syncB_reg;
    end
  end

  // ----------------------------------------
  // polarity select
  // ----------------------------------------
  // sync adds up to two clocks, hence the extra cycle of async latency
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      edgeSeen <= 1'b0;
    else
      edgeSeen <= risingSel ? (syncB_reg && !last_reg) : (!syncB_reg && last_reg); // see R12
  end

  chk_edge_polarity: assert property (@(posedge mclk) disable iff (!reset_n) // see R12
    edgeSeen |-> ($past(syncB_reg) != $past(last_reg)) && ($past(syncB_reg) == $past(risingSel)))
    else $error("pin edge of wrong polarity accepted");
endmodule : ext_edge_detect

`default_nettype wire

// File: verilog/context_shadow.sv
// shadow copies of the core context, saved on entry
// assumes capture and software write never need the same clock
`default_nettype none

module context_shadow
  import irq_entry_pkg::*;
#(
  parameter int COUNT = SHADOW_COUNT
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // capture from live context
  input wire logic captureEn,
  input wire logic [COUNT*8-1:0] captureData,
  // software access
  input wire logic wrEn,
  input wire logic [2:0] wrIndex,
  input wire logic [7:0] wrData,
  // shadow contents
  output logic [COUNT*8-1:0] shadowOut
);
  genvar i;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  generate
    for (i = 0; i < COUNT; i++)
    begin : g_byte
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          shadowOut[i*8 +: 8] <= SHADOW_RESET;
        else if (captureEn)
          shadowOut[i*8 +: 8] <= captureData[i*8 +: 8]; // see R16
        else if (wrEn && (wrIndex == 3'(i)))
          shadowOut[i*8 +: 8] <= wrData; // see R18
      end
    end
  endgenerate

  chk_shadow_capture: assert property (@(posedge mclk) disable iff (!reset_n) // see R16
    captureEn |=> shadowOut == $past(captureData))
    else $error("shadow did not take live context");
endmodule : context_shadow

`default_nettype wire

// File: verilog/cpu_interrupt_entry_logic.sv
// interrupt entry sequencer with apb registers and shadow bank
// assumes the core acts on its strobes in the clock they appear
`default_nettype none

module cpu_interrupt_entry_logic
  import irq_entry_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // event sources
  input wire logic extIntPin,
  input wire logic periphIrqReq,
  input wire logic periphWakeCapable,
  // core status
  input wire logic coreSleeping,
  input wire logic coreReturn,
  input wire logic [14:0] pcReturn,
  // live context
  input wire logic [7:0] liveW,
  input wire logic [7:0] liveStatus,
  input wire logic [7:0] liveBsr,
  input wire logic [7:0] livePclath,
  input wire logic [15:0] liveFsr0,
  input wire logic [15:0] liveFsr1,
  // pipeline control
  output logic [1:0] qPhase,
  output logic flushFetch,
  output logic insertNop,
  output logic pushPc,
  output logic [14:0] pushAddr,
  output logic loadVector,
  output logic [14:0] vectorPc,
  output logic popPc,
  output logic restoreCtx,
  output logic wakeUp,
  output logic globalIrqEnable,
  output logic extIrqFlag,
  // restored context
  output logic [7:0] restoreW,
  output logic [7:0] restoreStatus,
  output logic [7:0] restoreBsr,
  output logic [7:0] restorePclath,
  output logic [15:0] restoreFsr0,
  output logic [15:0] restoreFsr1
);
  entry_state_type entryState;
  logic extEnable;
  logic edgeRising;
  logic extEdge;
  logic [1:0] wakeHold;
  logic [SHADOW_COUNT*8-1:0] shadowOut;
  logic [SHADOW_COUNT*8-1:0] liveContext;
  logic endQ1;
  logic endQ4;
  logic pending;
  logic wakeSrc;
  logic takeReq;
  logic apbSetup;
  logic apbWrite;
  logic shadowHit;
  logic mapped;
  logic ctrlWr;
  logic edgeWr;
  logic shadowWr;
  logic [31:0] readMux;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic isShadow(input logic [11:0] addr);
    isShadow = (addr[11:7] == SHADOW_BANK) && (addr[6:5] == 2'h0) && (addr[1:0] == 2'h0);
  endfunction : isShadow

  function automatic logic [7:0] shadowByte(input logic [SHADOW_COUNT*8-1:0] bank,
                                            input logic [2:0] idx);
    shadowByte = bank[idx*8 +: 8];
  endfunction : shadowByte

  // ----------------------------------------
  // instruction cycle phases
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      qPhase <= PHASE_Q1;
    else
      qPhase <= qPhase + 2'h1;
  end

  assign endQ1 = (qPhase == PHASE_Q1);
  assign endQ4 = (qPhase == PHASE_Q4);

  // ----------------------------------------
  // pin edge and flag
  // ----------------------------------------
  ext_edge_detect u_edge (
    .mclk(mclk),
    .reset_n(reset_n),
    .extPin(extIntPin),
    .risingSel(edgeRising),
    .edgeSeen(extEdge)
  );

  // edge sets the flag whatever the enables; set wins over a write
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      extIrqFlag <= CTRL_RESET[CTRL_FLAG_BIT];
    else if (extEdge)
      extIrqFlag <= 1'b1; // see R13, R22, R5
    else if (ctrlWr)
      extIrqFlag <= pwdata[CTRL_FLAG_BIT];
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      extEnable <= CTRL_RESET[CTRL_INTE_BIT];
    else if (ctrlWr)
      extEnable <= pwdata[CTRL_INTE_BIT];
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      edgeRising <= EDGE_RESET;
    else if (edgeWr)
      edgeRising <= pwdata[EDGE_SEL_BIT]; // see R12
  end

  // ----------------------------------------
  // request and wake qualification
  // ----------------------------------------
  assign pending = (extIrqFlag && extEnable) || periphIrqReq; // see R11, R14
  // enables are software's job before sleep; only clockless sources count
  assign wakeSrc = (extIrqFlag && extEnable) || (periphIrqReq && periphWakeCapable); // see R6, R7
  // sampling only in q1, so one- and two-cycle instructions see equal latency
  assign takeReq = (entryState == ST_IDLE) && endQ1 && globalIrqEnable && pending
                   && !coreSleeping && (wakeHold == 2'h0); // see R3, R8, R14

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wakeUp <= 1'b0;
    else
      wakeUp <= coreSleeping && wakeSrc && !wakeUp; // see R6, R9
  end

  // the instruction after sleep completes before any branch
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wakeHold <= 2'h0;
    else if (wakeUp)
      wakeHold <= WAKE_HOLD_TCY + 2'h1; // see R10
    else if (endQ4 && (wakeHold != 2'h0))
      wakeHold <= wakeHold - 2'h1;
  end

  // ----------------------------------------
  // entry sequence
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      entryState <= ST_IDLE;
    else
    begin
      unique case (entryState)
        ST_IDLE:
          if (takeReq)
            entryState <= ST_SAMPLED; // see R1, R2, R4
        ST_SAMPLED:
          if (endQ4)
            entryState <= ST_NOP1;
        ST_NOP1:
          if (endQ4)
            entryState <= ST_NOP2;
        ST_NOP2:
          if (endQ4)
            entryState <= ST_VECTOR;
        ST_VECTOR:
          if (endQ4)
            entryState <= ST_IDLE;
        default:
          entryState <= ST_IDLE;
      endcase
    end
  end

  // strobes on the first clock of the first no-op cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flushFetch <= 1'b0;
      pushPc <= 1'b0;
      pushAddr <= '0;
    end
    else
    begin
      flushFetch <= (entryState == ST_SAMPLED) && endQ4; // see R20
      pushPc <= (entryState == ST_SAMPLED) && endQ4; // see R15
      if ((entryState == ST_SAMPLED) && endQ4)
        pushAddr <= pcReturn; // see R15
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      insertNop <= 1'b0;
    else if (endQ4)
      insertNop <= (entryState == ST_SAMPLED) || (entryState == ST_NOP1); // see R23
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loadVector <= 1'b0;
      vectorPc <= VECTOR_ADDR;
    end
    else
    begin
      loadVector <= (entryState == ST_NOP1) && endQ4; // see R20
      vectorPc <= VECTOR_ADDR;
    end
  end

  // hardware clear and set outrank a software write
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      globalIrqEnable <= CTRL_RESET[CTRL_GIE_BIT];
    else if ((entryState == ST_SAMPLED) && endQ4)
      globalIrqEnable <= 1'b0; // see R20
    else if (coreReturn)
      globalIrqEnable <= 1'b1; // see R21
    else if (ctrlWr)
      globalIrqEnable <= pwdata[CTRL_GIE_BIT];
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      popPc <= 1'b0;
      restoreCtx <= 1'b0;
    end
    else
    begin
      popPc <= coreReturn; // see R21
      restoreCtx <= coreReturn; // see R17, R21
    end
  end

  // ----------------------------------------
  // shadow bank
  // ----------------------------------------
  // timeout and powerdown bits are masked; the core keeps its live ones
  assign liveContext = {liveFsr1, liveFsr0, livePclath, liveBsr,
                        liveStatus & STATUS_SAVE_MASK, liveW}; // see R16

  context_shadow #(
    .COUNT(SHADOW_COUNT)
  ) u_shadow (
    .mclk(mclk),
    .reset_n(reset_n),
    .captureEn(flushFetch),
    .captureData(liveContext),
    .wrEn(shadowWr),
    .wrIndex(paddr[4:2]),
    .wrData(pwdata[7:0]),
    .shadowOut(shadowOut)
  );

  // restore outputs always show the shadows, so late shadow writes count
  assign restoreW = shadowByte(shadowOut, SH_W); // see R17, R18
  assign restoreStatus = shadowByte(shadowOut, SH_STATUS);
  assign restoreBsr = shadowByte(shadowOut, SH_BSR);
  assign restorePclath = shadowByte(shadowOut, SH_PC_HIGH_LATCH);
  assign restoreFsr0 = {shadowByte(shadowOut, SH_FSR0H), shadowByte(shadowOut, SH_FSR0L)};
  assign restoreFsr1 = {shadowByte(shadowOut, SH_FSR1H), shadowByte(shadowOut, SH_FSR1L)};

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  assign shadowHit = isShadow(paddr); // see R19
  assign mapped = (paddr == CTRL_OFF) || (paddr == EDGE_OFF) || (paddr == STATE_OFF) || shadowHit;
  assign ctrlWr = apbWrite && (paddr == CTRL_OFF);
  assign edgeWr = apbWrite && (paddr == EDGE_OFF);
  assign shadowWr = apbWrite && shadowHit; // see R19

  always_comb
  begin
    readMux = 32'h0000_0000;
    if (paddr == CTRL_OFF)
    begin
      readMux[CTRL_GIE_BIT] = globalIrqEnable;
      readMux[CTRL_INTE_BIT] = extEnable;
      readMux[CTRL_FLAG_BIT] = extIrqFlag;
    end
    else if (paddr == EDGE_OFF)
      readMux[EDGE_SEL_BIT] = edgeRising;
    else if (paddr == STATE_OFF)
      readMux[7:0] = {pending, wakeHold, entryState};
    else if (shadowHit)
      readMux[7:0] = shadowByte(shadowOut, paddr[4:2]); // see R19
  end

  // one wait-free access phase; reads latched at setup
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup && !mapped;
      if (apbSetup && !pwrite)
        prdata <= readMux;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_take;
    takeReq;
  endsequence

  sequence s_entry;
    (entryState == ST_SAMPLED) [*3] ##1 (entryState == ST_NOP1) [*4]
      ##1 (entryState == ST_NOP2) [*4] ##1 (entryState == ST_VECTOR);
  endsequence

  chk_entry_latency: assert property (@(posedge mclk) disable iff (!reset_n) // see R1, R4
    s_take |=> s_entry)
    else $error("entry did not reach vector on schedule");

  chk_entry_strobes: assert property (@(posedge mclk) disable iff (!reset_n) // see R20
    $rose(insertNop) |-> flushFetch && pushPc && !globalIrqEnable)
    else $error("flush, push or enable clear missing on entry");

  chk_nop_span: assert property (@(posedge mclk) disable iff (!reset_n) // see R23
    $rose(insertNop) |-> insertNop [*8] ##1 !insertNop)
    else $error("no-op cycles not two instruction cycles");

  chk_vector_load: assert property (@(posedge mclk) disable iff (!reset_n) // see R20
    loadVector |-> (entryState == ST_NOP2) && $past(entryState == ST_NOP1))
    else $error("vector loaded outside second no-op");

  chk_return_effects: assert property (@(posedge mclk) disable iff (!reset_n) // see R21
    coreReturn |=> popPc && restoreCtx && globalIrqEnable)
    else $error("return did not pop, restore and enable");

  chk_flag_set: assert property (@(posedge mclk) disable iff (!reset_n) // see R13
    extEdge |=> extIrqFlag)
    else $error("pin edge did not set flag");

  chk_wake_source: assert property (@(posedge mclk) disable iff (!reset_n) // see R6
    wakeUp |-> $past(coreSleeping) && $past(wakeSrc))
    else $error("wake without a capable source");

  chk_wake_hold: assert property (@(posedge mclk) disable iff (!reset_n) // see R10
    wakeUp |-> (entryState != ST_SAMPLED) [*4])
    else $error("entry sampled before post-sleep instruction");

  chk_no_take_disabled: assert property (@(posedge mclk) disable iff (!reset_n) // see R9
    (entryState == ST_IDLE) && !globalIrqEnable |=> entryState == ST_IDLE)
    else $error("entry started with global enable clear");
endmodule : cpu_interrupt_entry_logic

`default_nettype wire

// File: tb/core_model.sv
// stand-in for the core pipeline: program counter, live context, return and sleep
// assumes the bench pulses retReq and sleepReq for one clock each
`default_nettype none

module core_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // from the entry logic
  input wire logic flushFetch,
  input wire logic loadVector,
  input wire logic [14:0] vectorPc,
  input wire logic restoreCtx,
  input wire logic [7:0] restoreW,
  input wire logic wakeUp,
  // bench requests
  input wire logic retReq,
  input wire logic sleepReq,
  // to the entry logic
  output logic coreReturn,
  output logic coreSleeping,
  output logic [14:0] pcReturn,
  output logic [7:0] liveW,
  output logic [7:0] liveStatus,
  output logic [7:0] liveBsr,
  output logic [7:0] livePclath,
  output logic [15:0] liveFsr0,
  output logic [15:0] liveFsr1
);
  timeunit 1ns;
  timeprecision 1ns;
  // status with bits 4,3 set, so a shadow that keeps them shows up
  assign liveStatus = 8'hff;
  assign liveBsr = 8'h03;
  assign livePclath = 8'h12;
  assign liveFsr0 = 16'h2345;
  assign liveFsr1 = 16'h6789;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcReturn <= 15'h0100;
      liveW <= 8'h5a;
      coreReturn <= 1'b0;
      coreSleeping <= 1'b0;
    end
    else
    begin
      pcReturn <= loadVector ? vectorPc : pcReturn + 15'h0001;
      coreReturn <= retReq;
      if (sleepReq)
        coreSleeping <= 1'b1;
      else if (wakeUp)
        coreSleeping <= 1'b0;
      // service routine clobbers w, so a restore that fails is seen
      if (restoreCtx)
        liveW <= restoreW;
      else if (flushFetch)
        liveW <= ~liveW;
    end
  end
endmodule : core_model

`default_nettype wire

// File: tb/cpu_interrupt_entry_logic_test.sv
// self-checking bench for the interrupt entry logic
// assumes core_model stands in for the pipeline at the far side
`default_nettype none

module cpu_interrupt_entry_logic_test
  import irq_entry_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic extIntPin, periphIrqReq, periphWakeCapable, coreSleeping, coreReturn, retReq, sleepReq;
  logic [14:0] pcReturn, pushAddr, vectorPc, expPc;
  logic [7:0] liveW, liveStatus, liveBsr, livePclath, expW, expSt;
  logic [7:0] restoreW, restoreStatus, restoreBsr, restorePclath;
  logic [15:0] liveFsr0, liveFsr1, restoreFsr0, restoreFsr1;
  logic [1:0] qPhase;
  logic flushFetch, insertNop, pushPc, loadVector, popPc, restoreCtx, wakeUp;
  logic globalIrqEnable, extIrqFlag;
  int fail_count, checked, cyc, wakeCnt, flushCnt, base;

  cpu_interrupt_entry_logic DUT (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .extIntPin, .periphIrqReq, .periphWakeCapable, .coreSleeping,
    .coreReturn, .pcReturn, .liveW, .liveStatus, .liveBsr, .livePclath, .liveFsr0, .liveFsr1,
    .qPhase, .flushFetch, .insertNop, .pushPc, .pushAddr, .loadVector, .vectorPc, .popPc,
    .restoreCtx, .wakeUp, .globalIrqEnable, .extIrqFlag, .restoreW, .restoreStatus,
    .restoreBsr, .restorePclath, .restoreFsr0, .restoreFsr1);
  core_model partner (.mclk, .reset_n, .flushFetch, .loadVector, .vectorPc, .restoreCtx,
    .restoreW, .wakeUp, .retReq, .sleepReq, .coreReturn, .coreSleeping, .pcReturn, .liveW,
    .liveStatus, .liveBsr, .livePclath, .liveFsr0, .liveFsr1);

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    wakeCnt <= wakeCnt + int'(wakeUp === 1'b1);
    flushCnt <= flushCnt + int'(flushFetch === 1'b1);
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic sig(input int s);
    case (s)
      0: return flushFetch;
      1: return loadVector;
      2: return wakeUp;
      3: return extIrqFlag;
      default: return popPc;
    endcase
  endfunction : sig

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // bounded wait; a hang ends the run as a mismatch
  task automatic waitHi(input int s);
    int n;
    n = 0;
    while (sig(s) !== 1'b1 && n < 64)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 64)
    begin
      fail_count++;
      finish_test();
    end
  endtask : waitHi

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 32);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 32)
    begin
      fail_count++;
      finish_test();
    end
    @(posedge mclk);
  endtask : apb

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // random start phase, so the request lands anywhere in the cycle
  task automatic latency(input int src, input int lo, input int hi);
    int t0;
    int n;
    repeat (rnd() % 32'd4) @(posedge mclk);
    t0 = cyc;
    if (src == 0)
      extIntPin <= ~extIntPin;
    else
      periphIrqReq <= 1'b1;
    waitHi(0);
    chk("pushPc", pushPc, 1'b1);
    expW = liveW;
    expSt = liveStatus & STATUS_SAVE_MASK;
    // pc was taken one clock ago and the core steps it every clock
    expPc = pcReturn - 15'h0001;
    periphIrqReq <= 1'b0;
    @(posedge mclk);
    chk("pushAddr", pushAddr, expPc);
    chk("shadowW", restoreW, expW);
    chk("shadowStatus", restoreStatus, expSt);
    chk("shadowBsr", restoreBsr, 8'h03);
    chk("shadowPclath", restorePclath, 8'h12);
    chk("shadowFsr0", restoreFsr0, 16'h2345);
    chk("shadowFsr1", restoreFsr1, 16'h6789);
    chk("gieEntry", globalIrqEnable, 1'b0);
    waitHi(1);
    chk("vectorPc", vectorPc, VECTOR_ADDR);
    chk("nopFill", insertNop, 1'b1);
    n = 0;
    while (insertNop === 1'b1 && n < 16)
    begin
      @(posedge mclk);
      n++;
    end
    chk("latency", (cyc - t0 - 1 >= lo) && (cyc - t0 - 1 <= hi), 1'b1);
  endtask : latency

  task automatic doReturn();
    logic [31:0] v;
    v = rnd() & 32'h0000_00ff;
    apb(1'b1, CTRL_OFF, 32'h0000_0010);
    apb(1'b1, SHADOW_BASE, v);
    apb(1'b0, SHADOW_BASE, 32'h0);
    chk("shadowRead", rd, v);
    retReq <= 1'b1;
    @(posedge mclk);
    retReq <= 1'b0;
    waitHi(4);
    chk("restoreCtx", restoreCtx, 1'b1);
    chk("gieReturn", globalIrqEnable, 1'b1);
    chk("restoreW", restoreW, v);
    @(posedge mclk);
    chk("liveW", liveW, v);
  endtask : doReturn

  initial
  begin
    {psel, penable, pwrite, extIntPin, periphIrqReq, periphWakeCapable} = '0;
    {retReq, sleepReq} = '0;
    paddr = '0;
    pwdata = '0;
    reset_n = 1'b0;
    seed = 32'd38420;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrlReset", rd, 32'h0);
    apb(1'b0, 12'hfa0, 32'h0);
    chk("unmapped", err, 1'b1);
    apb(1'b1, EDGE_OFF, 32'h1);
    extIntPin <= 1'b1;
    waitHi(3);
    chk("flagNoGie", extIrqFlag, 1'b1);
    repeat (24) @(posedge mclk);
    chk("noEntry", flushCnt, 0);
    apb(1'b1, CTRL_OFF, 32'h0000_0090);
    extIntPin <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("fallIgnored", extIrqFlag, 1'b0);
    latency(0, 12, 20);
    doReturn();
    apb(1'b1, EDGE_OFF, 32'h0);
    latency(0, 12, 20);
    doReturn();
    latency(1, 12, 16);
    doReturn();
    // sleep with global enable off; enables set before sleeping
    apb(1'b1, CTRL_OFF, 32'h0000_0010);
    sleepReq <= 1'b1;
    @(posedge mclk);
    sleepReq <= 1'b0;
    periphIrqReq <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("noWake", wakeCnt, 0);
    periphWakeCapable <= 1'b1;
    waitHi(2);
    base = flushCnt;
    repeat (24) @(posedge mclk);
    chk("resumeOnly", flushCnt, base);
    periphIrqReq <= 1'b0;
    apb(1'b1, CTRL_OFF, 32'h0000_0090);
    sleepReq <= 1'b1;
    @(posedge mclk);
    sleepReq <= 1'b0;
    periphIrqReq <= 1'b1;
    waitHi(2);
    base = cyc;
    waitHi(0);
    periphIrqReq <= 1'b0;
    chk("wakeVector", cyc - base >= 4, 1'b1);
    doReturn();
    finish_test();
  end
endmodule : cpu_interrupt_entry_logic_test

`default_nettype wire
